// file: rtl/cke_pd_pkg.sv
// Shared constants for the clock-enable power-down sequencer and its host
package cke_pd_pkg;
  localparam int unsigned CKE_W          = 2;   // Input clock-enables per rank pair
  localparam int unsigned CS_W           = 4;   // Chip selects (four-rank capable)
  localparam int unsigned ODT_W          = 2;   // ODT signals
  localparam int unsigned ADDR_W         = 16;  // Address width
  localparam int unsigned CNT_W          = 4;   // Width of delay counters
  localparam logic [3:0]  IN_DIS_CLKS    = 4'h4; // Input-disable delay in clocks
  localparam logic [3:0]  OUT_DIS_CLKS   = 4'h2; // Output-disable delay in clocks
  localparam logic [3:0]  FIXED_OUT_CLKS = 4'h4; // Fixed-output interval in clocks
  localparam logic [3:0]  PAR_HOLD_CLKS  = 4'h1; // Extra parity buffer hold
  localparam logic [3:0]  CLK_STOP_CLKS  = 4'h8; // Stalled-clock detect window
  localparam int unsigned CFG_PD_EN_BIT  = 1;   // Power-down enable bit
  localparam int unsigned CFG_KEEP_BIT   = 0;   // Termination keep bit
  localparam logic [ADDR_W-1:0] FIXED_ADDR = 16'h0000; // Address level on exit
  localparam logic FIXED_STROBE = 1'b1;           // Strobe/WE level on exit (no-op)
endpackage

// file: rtl/cke_pd_if.sv
// Interface joining host controller and registering clock driver
`timescale 1ns/100ps
interface cke_pd_if;
  import cke_pd_pkg::*;
  logic [CKE_W-1:0]  input_clk_enable;   // Host clock-enables
  logic [CS_W-1:0]   input_chip_select;  // Host chip selects, active low
  logic [ODT_W-1:0]  input_odt;          // Host ODT
  logic              ras_n;              // Row strobe in
  logic              cas_n;              // Column strobe in
  logic              we_n;               // Write enable in
  logic [ADDR_W-1:0] addr;               // Address in
  logic              parity_input;       // Parity in
  logic              clk_run;            // Input clock running indication
  logic              inputs_gated;       // Device has disabled its command input buffers
  modport device (input input_clk_enable, input_chip_select, input_odt, ras_n, cas_n,
                  we_n, addr, parity_input, clk_run, output inputs_gated);
  modport host   (output input_clk_enable, input_chip_select, input_odt, ras_n, cas_n,
                  we_n, addr, parity_input, clk_run, input inputs_gated);
endinterface

// file: rtl/cke_pd_host.sv
// Host-side controller that sequences power-down entry and exit
`timescale 1ns/100ps
module cke_pd_host
  import cke_pd_pkg::*;
(
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rst_n,
  // User requests
  input  wire logic  pd_req,        // Level: request power-down
  input  wire logic  self_refresh,  // DRAM has taken self refresh
  input  wire logic  clk_stop_req,  // Level: stop the input clock too
  input  wire logic  four_rank_select,
  // Status
  output logic       in_pd,         // Power-down in effect
  output logic       may_float,     // Inputs may float now
  // Link
  cke_pd_if.host     link
);
  typedef enum logic [3:0] {H_RUN = 4'h1, H_PD = 4'h2, H_STOP = 4'h4, H_EXIT = 4'h8} hstate_e;
  hstate_e hs_q, hs_d;          // Host sequencing state
  logic    in_pd_q, in_pd_d;    // Registered status
  logic    flt_q, flt_d;        // Registered float permission

  // Next-state logic
  always_comb begin
    hs_d    = hs_q;
    in_pd_d = in_pd_q;
    flt_d   = 1'b0;
    case (hs_q)
      H_RUN: begin
        if (pd_req) begin
          hs_d    = H_PD;
          in_pd_d = 1'b1;
        end
      end
      H_PD: begin
        // Gating status comes from the same clock, so no synchroniser is needed
        flt_d = link.inputs_gated;
        if (clk_stop_req && self_refresh) begin
          hs_d = H_STOP;
        end else if (!pd_req) begin
          hs_d = H_EXIT;
        end
      end
      H_STOP: begin
        flt_d = link.inputs_gated;
        if (!clk_stop_req) begin
          hs_d = H_PD;
        end
      end
      default: begin
        hs_d    = H_RUN;
        in_pd_d = 1'b0;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_q       <= H_RUN;
      in_pd_q    <= 1'b0;
      flt_q      <= 1'b0;
    end else begin
      hs_q       <= hs_d;
      in_pd_q    <= in_pd_d;
      flt_q      <= flt_d;
    end
  end

  // Link drive: one select (two in four-rank mode) on the exit clock only;
  // selects zero and one never go low together, that would open a control word
  always_comb begin
    link.input_clk_enable  = (hs_q == H_RUN || hs_q == H_EXIT) ? '1 : '0;
    link.input_chip_select = '1;
    if (hs_q == H_EXIT) begin
      link.input_chip_select = four_rank_select ? 4'hA : 4'hE;
    end
    // ODT held high unless the clock is stopped, then driven low
    link.input_odt         = (hs_q == H_STOP) ? '0 : '1;
    link.ras_n             = 1'b1;
    link.cas_n             = 1'b1;
    link.we_n              = 1'b1;
    // Idle address pattern while running, distinct from the fixed exit level
    link.addr              = (hs_q == H_RUN || hs_q == H_EXIT) ? '1 : '0;
    link.parity_input      = 1'b0;
    link.clk_run           = (hs_q != H_STOP);
  end

  assign in_pd     = in_pd_q;
  assign may_float = flt_q;
endmodule

// file: rtl/cke_pd_device.sv
// Device-side clock-enable power-down control of a registering clock driver
`timescale 1ns/100ps
module cke_pd_device
  import cke_pd_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Configuration word bits
  input  wire logic [1:0]         power_down_config_word,
  // Link from host
  cke_pd_if.device                link,
  // Registered outputs to DRAM ranks
  output logic [CKE_W-1:0]        output_clk_enable,
  output logic [CS_W-1:0]         output_chip_select,
  output logic [ODT_W-1:0]        output_odt,
  output logic                    output_row_strobe,
  output logic                    output_column_strobe,
  output logic                    output_write_enable,
  output logic [ADDR_W-1:0]       output_address,
  // Output enables, low while driving
  output logic                    cmd_oe_n,
  output logic                    odt_oe_n,
  output logic                    cke_oe_n,
  output logic                    clock_outputs_oe_n,
  // Buffer gating status
  output logic                    input_bus_termination,
  output logic                    cmd_in_buf_en,
  output logic                    parity_buf_en,
  output logic                    odt_in_buf_en
);
  typedef enum logic [4:0] {
    S_RUN  = 5'h01, // Outputs follow inputs
    S_PD   = 5'h02, // Clock-enable power-down
    S_EXIT = 5'h04, // Fixed-output interval
    S_STOP = 5'h08, // Clock stopped standby
    S_CSH  = 5'h10  // Unused spare code guard
  } st_e;

  st_e                st_q, st_d;            // Main state
  logic [CNT_W-1:0]   cnt_q, cnt_d;          // Entry and exit delay counter
  logic [CNT_W-1:0]   stop_q, stop_d;        // Stopped-clock detect counter
  logic [CKE_W-1:0]   cke_prev_q;            // Last sampled clock-enables
  logic               keep_q, keep_d;        // Termination kept in this power-down
  logic [CKE_W-1:0]   qcke_q, qcke_d;
  logic [CS_W-1:0]    qcs_q, qcs_d;
  logic [ODT_W-1:0]   qodt_q, qodt_d;
  logic               qras_q, qras_d, qcas_q, qcas_d, qwe_q, qwe_d;
  logic [ADDR_W-1:0]  qaddr_q, qaddr_d;
  logic               cmd_oe_n_q, cmd_oe_n_d, odt_oe_n_q, odt_oe_n_d;
  logic               clko_oe_n_q, clko_oe_n_d, cke_oe_n_q, cke_oe_n_d;
  logic               ibt_q, ibt_d, cmdb_q, cmdb_d, parb_q, parb_d, odtb_q, odtb_d;
  logic               pd_en;
  logic               entry;

  assign pd_en = power_down_config_word[CFG_PD_EN_BIT];
  // Both latched low with at least one falling edge
  assign entry = pd_en && (link.input_clk_enable == '0) && (cke_prev_q != '0);

  // Next-state and output computation
  always_comb begin
    st_d        = st_q;
    cnt_d       = cnt_q;
    keep_d      = keep_q;
    stop_d      = link.clk_run ? '0 : ((stop_q == CLK_STOP_CLKS) ? stop_q : stop_q + 1'b1);
    qcke_d      = link.input_clk_enable;
    qcs_d       = link.input_chip_select;
    qodt_d      = link.input_odt;
    qras_d      = link.ras_n;
    qcas_d      = link.cas_n;
    qwe_d       = link.we_n;
    qaddr_d     = link.addr;
    cmd_oe_n_d  = 1'b0;
    odt_oe_n_d  = 1'b0;
    cke_oe_n_d  = 1'b0;
    clko_oe_n_d = 1'b0;
    ibt_d       = 1'b1;
    cmdb_d      = 1'b1;
    parb_d      = 1'b1;
    odtb_d      = 1'b1;
    case (st_q)
      S_RUN: begin
        if (entry) begin
          st_d   = S_PD;
          cnt_d  = '0;
          keep_d = power_down_config_word[CFG_KEEP_BIT];
        end
      end
      S_PD: begin
        cnt_d  = (cnt_q == IN_DIS_CLKS + PAR_HOLD_CLKS) ? cnt_q : cnt_q + 1'b1;
        qcke_d = link.input_clk_enable;
        if (!keep_q) begin
          qodt_d = '0;
        end
        // Inputs gated within input-disable delay, parity one clock later
        cmdb_d = (cnt_q + 1'b1) < IN_DIS_CLKS;
        parb_d = (cnt_q + 1'b1) < IN_DIS_CLKS + PAR_HOLD_CLKS;
        ibt_d  = keep_q || ((cnt_q + 1'b1) < IN_DIS_CLKS);
        odtb_d = keep_q || ((cnt_q + 1'b1) < IN_DIS_CLKS);
        cmd_oe_n_d = (cnt_q + 1'b1) >= OUT_DIS_CLKS;
        if (stop_q == CLK_STOP_CLKS) begin
          st_d = S_STOP;
        end else if (link.input_clk_enable != '0) begin
          st_d       = S_EXIT;
          cnt_d      = '0;
          cmd_oe_n_d = 1'b0;
          // Selects and command lines take safe levels together with the enables
          qcs_d      = '1;
          qras_d     = FIXED_STROBE;
          qcas_d     = FIXED_STROBE;
          qwe_d      = FIXED_STROBE;
          qaddr_d    = FIXED_ADDR;
        end
      end
      S_EXIT: begin
        cnt_d   = cnt_q + 1'b1;
        qcs_d   = link.input_chip_select;
        qodt_d  = keep_q ? link.input_odt : '0;
        qras_d  = FIXED_STROBE;
        qcas_d  = FIXED_STROBE;
        qwe_d   = FIXED_STROBE;
        qaddr_d = FIXED_ADDR;
        // The exit edge itself was the first fixed clock
        if (cnt_q + 1'b1 >= FIXED_OUT_CLKS - 1'b1) begin
          st_d = S_RUN;
        end
      end
      S_STOP: begin
        // Everything floats except the clock-enables held low
        qcke_d     = '0;
        qodt_d     = '0;
        cmd_oe_n_d = 1'b1;
        ibt_d      = 1'b0;
        cmdb_d     = 1'b0;
        parb_d     = 1'b0;
        odtb_d     = 1'b0;
        if (link.clk_run) begin
          // Clock back with enables still low: resume clock-enable power-down,
          // so only a rising enable runs the exit sequence
          st_d   = S_PD;
          ibt_d  = keep_q;
          odtb_d = keep_q;
        end else begin
          odt_oe_n_d  = 1'b1;
          clko_oe_n_d = 1'b1;
        end
      end
      default: begin
        st_d = S_RUN;
      end
    endcase
    if (st_d == S_PD && st_q == S_RUN) begin
      qcke_d = '0;
      // ODT goes low on the entry clock too when termination is switched off
      if (!keep_d) begin
        qodt_d = '0;
      end
    end
    if (st_d == S_PD) begin
      cke_oe_n_d = 1'b0;
    end
  end

  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q        <= S_RUN;
      cnt_q       <= '0;
      stop_q      <= '0;
      cke_prev_q  <= '0;
      keep_q      <= 1'b0;
      qcke_q      <= '0;
      qcs_q       <= '1;
      qodt_q      <= '0;
      qras_q      <= 1'b1;
      qcas_q      <= 1'b1;
      qwe_q       <= 1'b1;
      qaddr_q     <= '0;
      cmd_oe_n_q  <= 1'b1;
      odt_oe_n_q  <= 1'b0;
      cke_oe_n_q  <= 1'b0;
      clko_oe_n_q <= 1'b0;
      ibt_q       <= 1'b0;
      cmdb_q      <= 1'b1;
      parb_q      <= 1'b1;
      odtb_q      <= 1'b1;
    end else begin
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      stop_q      <= stop_d;
      cke_prev_q  <= link.input_clk_enable;
      keep_q      <= keep_d;
      qcke_q      <= qcke_d;
      qcs_q       <= qcs_d;
      qodt_q      <= qodt_d;
      qras_q      <= qras_d;
      qcas_q      <= qcas_d;
      qwe_q       <= qwe_d;
      qaddr_q     <= qaddr_d;
      cmd_oe_n_q  <= cmd_oe_n_d;
      odt_oe_n_q  <= odt_oe_n_d;
      cke_oe_n_q  <= cke_oe_n_d;
      clko_oe_n_q <= clko_oe_n_d;
      ibt_q       <= ibt_d;
      cmdb_q      <= cmdb_d;
      parb_q      <= parb_d;
      odtb_q      <= odtb_d;
    end
  end

  // Outputs straight from flip-flops
  assign output_clk_enable     = qcke_q;
  assign output_chip_select    = qcs_q;
  assign output_odt            = qodt_q;
  assign output_row_strobe     = qras_q;
  assign output_column_strobe  = qcas_q;
  assign output_write_enable   = qwe_q;
  assign output_address        = qaddr_q;
  assign cmd_oe_n              = cmd_oe_n_q;
  assign odt_oe_n              = odt_oe_n_q;
  assign cke_oe_n              = cke_oe_n_q;
  assign clock_outputs_oe_n    = clko_oe_n_q;
  assign input_bus_termination = ibt_q;
  assign cmd_in_buf_en         = cmdb_q;
  assign parity_buf_en         = parb_q;
  assign odt_in_buf_en         = odtb_q;
  assign link.inputs_gated     = ~cmdb_q;
endmodule

// file: verification/cke_pd_sva.sv
// Concurrent checks on the power-down link and the device outputs
`timescale 1ns/100ps
module cke_pd_sva
  import cke_pd_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst_n,
  // Configuration and link
  input wire logic [1:0]        power_down_config_word,
  input wire logic [CKE_W-1:0]  input_clk_enable,
  input wire logic [CS_W-1:0]   input_chip_select,
  input wire logic [ODT_W-1:0]  input_odt,
  input wire logic              clk_run,
  // Device outputs
  input wire logic [CKE_W-1:0]  output_clk_enable,
  input wire logic [CS_W-1:0]   output_chip_select,
  input wire logic [ODT_W-1:0]  output_odt,
  input wire logic              output_row_strobe,
  input wire logic              output_column_strobe,
  input wire logic              output_write_enable,
  input wire logic [ADDR_W-1:0] output_address,
  input wire logic              cmd_oe_n,
  input wire logic              odt_oe_n,
  input wire logic              cke_oe_n,
  input wire logic              clock_outputs_oe_n,
  input wire logic              input_bus_termination,
  input wire logic              cmd_in_buf_en,
  input wire logic              parity_buf_en,
  input wire logic              odt_in_buf_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic pd_en;  // Power-down allowed
  logic keep;   // Termination kept on in power-down
  assign pd_en = power_down_config_word[CFG_PD_EN_BIT];
  assign keep  = power_down_config_word[CFG_KEEP_BIT];
  // Entry: both enables now low, at least one high the clock before, while allowed
  sequence entry_s;
    pd_en && $fell(|input_clk_enable);
  endsequence
  // Exit: an enable just came back high
  sequence exit_s;
    pd_en && $rose(|input_clk_enable);
  endsequence
  entry_cke_low_a: assert property (entry_s |=> output_clk_enable == '0)
    else $error("Output enables not low after entry");
  input_gating_a: assert property (entry_s |=> ##[0:4] (!cmd_in_buf_en &&
    input_bus_termination == keep && odt_in_buf_en == keep))
    else $error("Input buffers not gated as configured");
  parity_hold_a: assert property ($fell(cmd_in_buf_en) |-> parity_buf_en ##1 !parity_buf_en)
    else $error("Parity buffer not held one extra clock");
  out_float_a: assert property (pd_en && $fell(|output_clk_enable) |-> ##[1:2] cmd_oe_n)
    else $error("Command outputs not floated in time");
  pd_odt_low_a: assert property (output_clk_enable == '0 && input_clk_enable == '0
    && pd_en && !keep && !odt_oe_n |-> output_odt == '0)
    else $error("Output ODT not low in power-down");
  // Drivers return one registered clock after the input clock does
  clk_drive_a: assert property (output_clk_enable == '0 && clk_run && $past(clk_run)
    |-> !clock_outputs_oe_n && !cke_oe_n)
    else $error("Clock or enable outputs not driven");
  exit_cke_a: assert property (exit_s |=> output_clk_enable == $past(input_clk_enable))
    else $error("Output enables did not follow on exit");
  exit_cs_a: assert property (exit_s |=> &output_chip_select
    ##1 output_chip_select == $past(input_chip_select))
    else $error("Chip selects wrong on exit");
  fixed_out_a: assert property (exit_s |=> (output_row_strobe && output_column_strobe
    && output_write_enable && output_address == FIXED_ADDR) [*4])
    else $error("Fixed output levels not held");
  exit_odt_a: assert property (exit_s |=> (keep ? output_odt == $past(input_odt)
    : output_odt == '0))
    else $error("Output ODT wrong on exit");
  stop_float_a: assert property ((!clk_run && output_clk_enable == '0) [*8]
    |-> ##[0:3] (cmd_oe_n && odt_oe_n && clock_outputs_oe_n && !cke_oe_n))
    else $error("Stopped clock outputs not floated");
  // Main scenarios reached
  cover property (entry_s ##0 keep);
  cover property (entry_s ##0 !keep);
  cover property (exit_s);
  cover property ($fell(clk_run));
endmodule

// file: verification/test_cke_power_down_control.sv
// Self-checking bench for the power-down host and device pair
`timescale 1ns/100ps
module test_cke_power_down_control;
  import cke_pd_pkg::*;
  logic              clk = 1'b0;     // 125 MHz clock
  logic              rst_n;          // Async reset, low active
  logic              pd_req, self_refresh, clk_stop_req, four_rank_select;
  logic              in_pd, may_float;
  logic [1:0]        cfg;            // Configuration word bits
  logic [CKE_W-1:0]  output_clk_enable;
  logic [CS_W-1:0]   output_chip_select;
  logic [ODT_W-1:0]  output_odt;
  logic              output_row_strobe, output_column_strobe, output_write_enable;
  logic [ADDR_W-1:0] output_address;
  logic              cmd_oe_n, odt_oe_n, cke_oe_n, clock_outputs_oe_n;
  logic              input_bus_termination, cmd_in_buf_en, parity_buf_en, odt_in_buf_en;
  int                mismatches = 0; // Failed comparisons
  int                checked = 0;    // Comparisons made
  int                cyc = 0;        // Cycles run, for the hang limit
  logic [31:0]       seed = 32'h1;   // Xorshift state
  logic [31:0]       r;              // Current random draw
  cke_pd_if link ();
  cke_pd_host u_cke_pd_host (.clk, .rst_n, .pd_req, .self_refresh, .clk_stop_req,
    .four_rank_select, .in_pd, .may_float, .link(link.host));
  cke_pd_device u_cke_pd_device (.clk, .rst_n, .power_down_config_word(cfg),
    .link(link.device), .output_clk_enable, .output_chip_select, .output_odt,
    .output_row_strobe, .output_column_strobe, .output_write_enable, .output_address,
    .cmd_oe_n, .odt_oe_n, .cke_oe_n, .clock_outputs_oe_n, .input_bus_termination,
    .cmd_in_buf_en, .parity_buf_en, .odt_in_buf_en);
  cke_pd_sva u_cke_pd_sva (.clk, .rst_n, .power_down_config_word(cfg),
    .input_clk_enable(link.input_clk_enable), .input_chip_select(link.input_chip_select),
    .input_odt(link.input_odt), .clk_run(link.clk_run), .output_clk_enable,
    .output_chip_select, .output_odt, .output_row_strobe, .output_column_strobe,
    .output_write_enable, .output_address, .cmd_oe_n, .odt_oe_n, .cke_oe_n,
    .clock_outputs_oe_n, .input_bus_termination, .cmd_in_buf_en, .parity_buf_en,
    .odt_in_buf_en);
  // Free-running clock
  always #4 clk = ~clk;
  // Hang limit: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      conclude();
    end
  end
  // Repeatable random source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Termination and ODT buffer state expected in power-down
  function automatic logic [1:0] exp_gate(input logic keep_on);
    return {keep_on, keep_on};
  endfunction
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Wait on the host status, bounded so a hang shows as a mismatch
  task automatic wait_pd(input logic v);
    int k;
    k = 0;
    while (in_pd !== v && k < 100) begin
      @(negedge clk);
      k++;
    end
    chk(in_pd, v);
  endtask
  // Verdict and end of run
  task automatic conclude();
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence: inputs change on the falling edge only
  initial begin
    rst_n = 1'b0;
    pd_req = 1'b0;
    self_refresh = 1'b0;
    clk_stop_req = 1'b0;
    four_rank_select = 1'b0;
    cfg = 2'h0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    // Enable bit clear: a request must leave the device running
    pd_req = 1'b1;
    repeat (12) @(negedge clk);
    chk(cmd_in_buf_en, 1'b1);
    chk(cmd_oe_n, 1'b0);
    pd_req = 1'b0;
    repeat (12) @(negedge clk);
    // Random mix of both termination modes, some with the clock stopped
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      cfg = {1'b1, r[0]};
      four_rank_select = r[1];
      pd_req = 1'b1;
      wait_pd(1'b1);
      repeat (8 + r[5:3]) @(negedge clk);
      chk(output_clk_enable, 2'h0);
      chk({input_bus_termination, odt_in_buf_en}, exp_gate(r[0]));
      chk(cmd_in_buf_en | parity_buf_en, 1'b0);
      chk(cmd_oe_n, 1'b1);
      chk(clock_outputs_oe_n, 1'b0);
      chk(may_float, 1'b1);
      if (!r[0]) begin
        chk(output_odt, 2'h0);
      end else begin
        chk(output_odt, 2'h3);
      end
      // Clock stop only once self refresh is in place
      if (r[2] || i == 0) begin
        self_refresh = 1'b1;
        clk_stop_req = 1'b1;
        repeat (16) @(negedge clk);
        chk({cmd_oe_n, odt_oe_n, clock_outputs_oe_n, cke_oe_n}, 4'hE);
        chk(output_clk_enable, 2'h0);
        clk_stop_req = 1'b0;
        repeat (4) @(negedge clk);
      end
      pd_req = 1'b0;
      wait_pd(1'b0);
      // First exit clock: enables up, selects high, fixed address level
      chk({output_clk_enable, output_chip_select}, 6'h3F);
      chk(output_address, FIXED_ADDR);
      repeat (8) @(negedge clk);
      chk(output_clk_enable, 2'h3);
      chk({cmd_oe_n, cmd_in_buf_en}, 2'h1);
      chk({output_odt, output_address}, 18'h3FFFF);
      self_refresh = 1'b0;
    end
    conclude();
  end
endmodule
